//--- design/eeprom_spi_front.sv
/*
 SPI client front end of a serial EEPROM, with its receive FIFO.
 Assumes an external host drives cs_n, sck and si; all pins are sampled
 by clk through two flip-flops. The opcode engine sits on the user side.
*/
// Operation
// - Deselected means standby and output released
// - Input ignored while deselected
// - Select edges frame every command sequence
// - Stay out of standby during write
// - Output changes on falling clock only
// - Input captured on rising clock edges
// - Output released while paused
// - Pause suspends without losing sequence state
// - Legacy mode: pin guards status and array; array_guard here follows only the block bits, not the pin
// - Enhanced mode: pin guards partition zones
// - Array is 2048 pages of 256
// - Status register is sixteen bits
// - Security register: serial number, lockable page
// - Eight partition registers, eight bits each
// - Four partition protection levels
// - Identification register forty bits, read-only
// - Only SPI modes 0 and 3
// - Bytes enter MSB first from first rise
// - Output MSB first after command bytes
// - Pause changes only while clock low
// - Pause ignores input and clock
// - Select rising while paused aborts sequence

module spi_rx_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic do_wr, do_rd;

    assign in_ready = cnt_r != DEPTH[AW:0];
    assign out_valid = cnt_r != '0;
    assign out_data = mem_r[rd_r];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    always_comb begin
        mem_nxt = mem_r;
        wr_nxt = wr_r;
        rd_nxt = rd_r;
        cnt_nxt = cnt_r;
        if (do_wr) begin
            mem_nxt[wr_r] = in_data;
            wr_nxt = wr_r + 1'b1;
        end
        if (do_rd) begin
            rd_nxt = rd_r + 1'b1;
        end
        if (do_wr && !do_rd) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (do_rd && !do_wr) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
            mem_r <= mem_nxt;
        end
    end
endmodule

module eeprom_spi_front
    import eeprom_spi_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    output logic so_o,
    output logic so_oe,
    output logic [eeprom_spi_pkg::BYTE_W-1:0] rx_byte,
    output logic rx_first,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rx_overrun,
    input wire logic [eeprom_spi_pkg::BYTE_W-1:0] tx_data,
    input wire logic tx_enable,
    output logic tx_taken,
    output logic frame_start,
    output logic frame_end,
    output logic frame_abort,
    output logic standby,
    output logic paused,
    input wire logic write_busy,
    output logic [eeprom_spi_pkg::PAGE_IDX_W-1:0] page_index,
    output logic [eeprom_spi_pkg::BYTE_IDX_W-1:0] page_offset,
    input wire logic protection_mode_select,
    input wire logic [eeprom_spi_pkg::STATUS_W-1:0] status_word,
    input wire logic [eeprom_spi_pkg::PARTITION_W-1:0] partition_register
        [eeprom_spi_pkg::PARTITION_COUNT],
    output logic status_guard,
    output logic array_guard,
    output logic zone_pin_guard,
    output logic zone_sw_guard
);
    import eeprom_spi_pkg::*;

    // Pin synchronisers: {cs_n, hold_n, wp_n, sck, si}
    logic [PIN_W-1:0] pin_m_r, pin_s_r;
    logic cs_s, hold_s, wp_s, sck_s, si_s;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_m_r <= PIN_RST;
            pin_s_r <= PIN_RST;
        end else begin
            pin_m_r <= {cs_n, hold_n, wp_n, sck, si};
            pin_s_r <= pin_m_r;
        end
    end
    assign {cs_s, hold_s, wp_s, sck_s, si_s} = pin_s_r;

    logic cs_d_r, cs_d_nxt, sck_d_r, sck_d_nxt, held_r, held_nxt;
    logic started_r, started_nxt, out_phase_r, out_phase_nxt, so_r, so_nxt;
    logic [2:0] bit_cnt_r, bit_cnt_nxt, byte_cnt_r, byte_cnt_nxt;
    logic [BYTE_W-1:0] rx_sh_r, rx_sh_nxt, tx_sh_r, tx_sh_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic start_r, start_nxt, end_r, end_nxt, abort_r, abort_nxt;
    logic taken_r, taken_nxt;
    logic cs_fall, cs_rise, active, rise, fall, push, push_ready;
    logic [BYTE_W-1:0] push_byte;

    assign cs_fall = cs_d_r && !cs_s;
    assign cs_rise = cs_s && !cs_d_r;
    // Edges count only while selected and not paused
    assign active = !cs_s && !held_r && !cs_fall;
    assign rise = active && sck_s && !sck_d_r;
    // A falling edge before the first rise is mode 3 idle-high, not data
    assign fall = active && !sck_s && sck_d_r && started_r;
    assign push_byte = {rx_sh_r[BYTE_W-2:0], si_s};
    assign push = rise && bit_cnt_r == BIT_LAST;

    always_comb begin
        cs_d_nxt = cs_s;
        sck_d_nxt = sck_s;
        held_nxt = held_r;
        started_nxt = started_r;
        out_phase_nxt = out_phase_r;
        so_nxt = so_r;
        bit_cnt_nxt = bit_cnt_r;
        byte_cnt_nxt = byte_cnt_r;
        rx_sh_nxt = rx_sh_r;
        tx_sh_nxt = tx_sh_r;
        addr_nxt = addr_r;
        start_nxt = cs_fall;
        end_nxt = cs_rise && !held_r;
        abort_nxt = cs_rise && held_r;
        taken_nxt = 1'b0;
        if (cs_s) begin
            held_nxt = 1'b0;
        end else if (!sck_s) begin
            held_nxt = !hold_s;
        end
        if (cs_fall) begin
            started_nxt = 1'b0;
            out_phase_nxt = 1'b0;
            so_nxt = 1'b0;
            bit_cnt_nxt = '0;
            byte_cnt_nxt = '0;
        end
        if (rise) begin
            started_nxt = 1'b1;
            rx_sh_nxt = push_byte;
            bit_cnt_nxt = bit_cnt_r + 3'h1;
            if (push && byte_cnt_r != BYTE_CNT_MAX) begin
                byte_cnt_nxt = byte_cnt_r + 3'h1;
            end
            if (push && byte_cnt_r != '0 && byte_cnt_r != BYTE_CNT_MAX) begin
                addr_nxt = {addr_r[ADDR_W-BYTE_W-1:0], push_byte};
            end
        end
        if (fall) begin
            if (bit_cnt_r == '0 && tx_enable) begin
                out_phase_nxt = 1'b1;
                so_nxt = tx_data[BYTE_W-1];
                tx_sh_nxt = {tx_data[BYTE_W-2:0], 1'b0};
                taken_nxt = 1'b1;
            end else if (bit_cnt_r == '0) begin
                out_phase_nxt = 1'b0;
            end else if (out_phase_r) begin
                so_nxt = tx_sh_r[BYTE_W-1];
                tx_sh_nxt = {tx_sh_r[BYTE_W-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_d_r <= 1'b1;
            sck_d_r <= 1'b0;
            held_r <= 1'b0;
            started_r <= 1'b0;
            out_phase_r <= 1'b0;
            so_r <= 1'b0;
            bit_cnt_r <= '0;
            byte_cnt_r <= '0;
            rx_sh_r <= '0;
            tx_sh_r <= '0;
            addr_r <= '0;
            start_r <= 1'b0;
            end_r <= 1'b0;
            abort_r <= 1'b0;
            taken_r <= 1'b0;
        end else begin
            cs_d_r <= cs_d_nxt;
            sck_d_r <= sck_d_nxt;
            held_r <= held_nxt;
            started_r <= started_nxt;
            out_phase_r <= out_phase_nxt;
            so_r <= so_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            byte_cnt_r <= byte_cnt_nxt;
            rx_sh_r <= rx_sh_nxt;
            tx_sh_r <= tx_sh_nxt;
            addr_r <= addr_nxt;
            start_r <= start_nxt;
            end_r <= end_nxt;
            abort_r <= abort_nxt;
            taken_r <= taken_nxt;
        end
    end

    // Pin released when deselected, paused or outside data phases
    assign so_oe = out_phase_r && !cs_s && !held_r;
    assign so_o = so_r;
    assign standby = cs_s && !write_busy;
    assign paused = held_r;
    assign frame_start = start_r;
    assign frame_end = end_r;
    assign frame_abort = abort_r;
    assign tx_taken = taken_r;
    assign rx_overrun = push && !push_ready;
    assign page_index = addr_r[BYTE_IDX_W +: PAGE_IDX_W];
    assign page_offset = addr_r[BYTE_IDX_W-1:0];

    logic [FIFO_W-1:0] fifo_out;
    spi_rx_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk(clk),
        .rst(rst),
        .in_data({byte_cnt_r == '0, push_byte}),
        .in_valid(push),
        .in_ready(push_ready),
        .out_data(fifo_out),
        .out_valid(rx_valid),
        .out_ready(rx_ready)
    );
    assign {rx_first, rx_byte} = fifo_out;

    // Write protection guards
    logic [PARTITION_COUNT-1:0] zone_hit;
    prot_level_t zone_level;
    for (genvar g = 0; g < PARTITION_COUNT; g++) begin : g_zone
        assign zone_hit[g] = addr_r[ADDR_ZONE_LO +: PART_END_W] <=
            partition_register[g][PART_END_LO +: PART_END_W];
    end
    always_comb begin
        zone_level = PROT_NONE;
        for (int i = PARTITION_COUNT - 1; i >= 0; i--) begin
            if (zone_hit[i]) begin
                zone_level = prot_level_t'(partition_register[i][PART_BEH_LO +: 2]);
            end
        end
    end
    assign status_guard = !protection_mode_select && status_word[STATUS_WPEN_POS]
        && !wp_s;
    assign array_guard = !protection_mode_select
        && status_word[STATUS_BP_LO +: STATUS_BP_W] != '0;
    assign zone_pin_guard = protection_mode_select && !wp_s
        && zone_level == PROT_PIN;
    assign zone_sw_guard = protection_mode_select
        && (zone_level == PROT_SW || zone_level == PROT_SW_LOCKED);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_so_hiz_desel: assert property (cs_s |-> !so_oe)
        else $error("output driven while deselected");
    a_no_rx_desel: assert property (cs_s |-> !push)
        else $error("byte taken while deselected");
    a_frame_start: assert property (cs_fall |=> start_r && bit_cnt_r == 3'h0)
        else $error("select fall did not restart the frame");
    a_busy_standby: assert property (write_busy |-> !standby)
        else $error("standby during write cycle");
    a_so_fall_only: assert property ($changed(so_r) |-> $past(fall || cs_fall))
        else $error("output changed off a falling edge");
    a_push_eighth: assert property (push |=> bit_cnt_r == 3'h0 && $past(bit_cnt_r) == 3'h7)
        else $error("byte completed on wrong bit");
    a_hold_hiz: assert property (held_r |-> !so_oe)
        else $error("output driven while paused");
    a_hold_keeps: assert property (held_r && !cs_s |=> $stable(bit_cnt_r) && $stable(rx_sh_r))
        else $error("sequence moved while paused");
    a_hold_sck_low: assert property ($changed(held_r) && !$past(cs_s) |-> !$past(sck_s))
        else $error("pause changed while clock high");
    a_abort_held: assert property (cs_rise && held_r |=> abort_r && !end_r)
        else $error("held deselect did not abort");
    a_oe_phase: assert property (so_oe |-> out_phase_r && started_r)
        else $error("output driven outside data phase");
    c_byte_rx: cover property (push ##[1:400] end_r);
    c_hold: cover property (held_r ##[1:400] !held_r);
    c_tx_load: cover property (taken_r ##[1:100] so_oe);
    c_abort: cover property (abort_r);
endmodule

//--- design/eeprom_spi_pkg.sv
/*
 Shared constants for the serial EEPROM SPI client front end.
 Assumes one 40 MHz system clock samples every pin of the SPI link.
*/
package eeprom_spi_pkg;
    localparam int BYTE_W = 8;
    localparam int PAGE_COUNT = 2048;
    localparam int PAGE_BYTES = 256;
    localparam int PAGE_IDX_W = $clog2(PAGE_COUNT);
    localparam int BYTE_IDX_W = $clog2(PAGE_BYTES);
    localparam int ADDR_W = 24;
    localparam int ADDR_BYTES = 3;
    localparam int STATUS_W = 16;
    localparam int STATUS_WPEN_POS = 7;
    localparam int STATUS_BP_LO = 2;
    localparam int STATUS_BP_W = 2;
    localparam int SERIAL_NUM_W = 128;
    localparam int ID_PAGE_BYTES = 256;
    localparam int PARTITION_COUNT = 8;
    localparam int PARTITION_W = 8;
    localparam int PART_END_LO = 0;
    localparam int PART_END_W = 6;
    localparam int PART_BEH_LO = 6;
    localparam int ADDR_ZONE_LO = 13;
    localparam int ID_W = 40;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_W = BYTE_W + 1;
    localparam int PIN_W = 5;
    localparam logic [4:0] PIN_RST = 5'h1c;        // Select, pause, protect high; clock, data low
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BYTE_CNT_MAX = 3'h4;
    // Partition behaviour field, two bits
    typedef enum logic [1:0] {
        PROT_NONE, PROT_SW, PROT_PIN, PROT_SW_LOCKED
    } prot_level_t;
endpackage

//--- dv/spi_host_model.sv
/*
 SPI host model: drives select, clock, data and pause in modes 0 and 3.
 Assumes clk is the 40 MHz system clock; a half period is 4 clocks.
*/
module spi_host_model (
    input wire logic clk,
    input wire logic so_o,
    input wire logic so_oe,
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic cpol = 1'b0;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b1;
        hold_n = 1'b1;
    end
    task automatic half();
        repeat (4) @(negedge clk);
    endtask
    task automatic hold(input logic v);
        hold_n = v;
        half();
    endtask
    task automatic sel(input logic m3);
        cpol = m3;
        sck = m3;
        half();
        cs_n = 1'b0;
        half();
    endtask
    task automatic desel();
        sck = cpol;
        half();
        cs_n = 1'b1;
        si = ~si;
        half();
    endtask
    // One byte each way; oe returns {any, all} of so_oe at the rises
    task automatic xfer(input logic [7:0] tx, input int pz, output logic [7:0] rx,
                        output logic [1:0] oe);
        oe = 2'b01;
        for (int i = 7; i >= 0; i--) begin
            sck = 1'b0;
            si = tx[i];
            half();
            if (i == pz) begin
                hold(1'b0);
                sck = 1'b1;
                half();
                sck = 1'b0;
                half();
                hold(1'b1);
            end
            sck = 1'b1;
            rx[i] = so_oe ? so_o : !so_o; // Released line reads back inverted
            oe[1] = oe[1] | so_oe;
            oe[0] = oe[0] & so_oe;
            half();
        end
    endtask
endmodule

//--- dv/eeprom_spi_front_tb_top.sv
/*
 Self-checking bench for the SPI client front end: frames, pause, FIFO, guards.
 Assumes spi_host_model paces the link at 200 ns per clock period.
*/
module eeprom_spi_front_tb_top import eeprom_spi_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cs_n, sck, si, hold_n, so_o, so_oe, rx_first, rx_valid, rx_overrun, tx_taken;
    logic frame_start, frame_end, frame_abort, standby, paused;
    logic status_guard, array_guard, zone_pin_guard, zone_sw_guard;
    logic wp_n = 1'b1;
    logic rx_ready = 1'b0;
    logic tx_enable = 1'b0;
    logic write_busy = 1'b0;
    logic mode_sel = 1'b0;
    logic [BYTE_W-1:0] tx_data = 8'ha5;
    logic [BYTE_W-1:0] rx_byte;
    logic [STATUS_W-1:0] status_word = 16'h0000;
    logic [PARTITION_W-1:0] part [PARTITION_COUNT] = '{default: 8'h00};
    logic [PAGE_IDX_W-1:0] page_index;
    logic [BYTE_IDX_W-1:0] page_offset;
    int n_mismatch = 0;
    int samples_checked = 0;
    int n_start = 0, n_end = 0, n_abort = 0, n_ovr = 0, n_pz = 0, n_pz_oe = 0, n_taken = 0;
    always #12.5 clk = ~clk;
    spi_host_model u_host (.clk, .so_o, .so_oe, .cs_n, .sck, .si, .hold_n);
    eeprom_spi_front u_dut (.clk, .rst, .cs_n, .sck, .si, .hold_n, .wp_n, .so_o, .so_oe,
        .rx_byte, .rx_first, .rx_valid, .rx_ready, .rx_overrun, .tx_data, .tx_enable,
        .tx_taken, .frame_start, .frame_end, .frame_abort, .standby, .paused, .write_busy,
        .page_index, .page_offset, .protection_mode_select(mode_sel), .status_word,
        .partition_register(part), .status_guard, .array_guard, .zone_pin_guard,
        .zone_sw_guard);
    always @(posedge clk) begin
        n_start += frame_start;
        n_end += frame_end;
        n_abort += frame_abort;
        n_ovr += rx_overrun;
        n_pz += paused;
        n_pz_oe += paused & so_oe;
        n_taken += tx_taken;
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic pop(input logic [7:0] b, input logic f);
        int k;
        k = 0;
        while (rx_valid !== 1'b1 && k < 50) begin
            @(negedge clk);
            k++;
        end
        if (k == 50) begin
            n_mismatch++;
            summarize();
        end
        chk("rx_byte", 16'(b), 16'(rx_byte));
        chk("rx_first", 16'(f), 16'(rx_first));
        rx_ready = 1'b1;
        @(negedge clk);
        rx_ready = 1'b0;
        @(negedge clk);
    endtask
    task automatic frame(input logic m3, input int pz);
        logic [7:0] r;
        logic [1:0] oe;
        logic [7:0] cmd [4] = '{8'h03, 8'h05, 8'h12, 8'h34};
        int s;
        int t;
        s = n_start;
        u_host.sel(m3);
        chk("frame_start", 16'(s + 1), 16'(n_start));
        foreach (cmd[i]) begin
            u_host.xfer(cmd[i], -1, r, oe);
            chk("oe_cmd", 16'h0000, 16'(oe[1]));
        end
        repeat (2) @(negedge clk);
        chk("page_index", 16'h0512, 16'(page_index));
        chk("page_offset", 16'h0034, 16'(page_offset));
        t = n_taken;
        tx_enable = 1'b1;
        u_host.xfer(8'h00, pz, r, oe);
        tx_enable = 1'b0;
        chk("so_data", 16'h00a5, 16'(r));
        chk("oe_data", 16'h0001, 16'(oe[0]));
        chk("tx_taken", 16'(t + 1), 16'(n_taken));
        s = n_end;
        u_host.desel();
        chk("so_oe_idle", 16'h0000, 16'(so_oe));
        chk("frame_end", 16'(s + 1), 16'(n_end));
        foreach (cmd[i]) pop(cmd[i], i == 0);
        pop(8'h00, 1'b0);
        chk("rx_valid", 16'h0000, 16'(rx_valid));
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
    initial begin
        logic [7:0] r;
        logic [1:0] oe;
        repeat (4) @(negedge clk);
        chk("so_oe_rst", 16'h0000, 16'(so_oe));
        chk("standby_rst", 16'h0001, 16'(standby));
        rst = 1'b0;
        repeat (3) @(negedge clk);
        for (int m = 0; m < 3; m++) begin
            frame(m == 1, m == 2 ? 3 : -1);
            $display("test frame %0d done", m);
        end
        chk("paused_seen", 16'h0001, 16'(n_pz > 0));
        chk("oe_paused", 16'h0000, 16'(n_pz_oe));
        u_host.sel(1'b0);
        u_host.xfer(8'h06, -1, r, oe);
        u_host.hold(1'b0);
        u_host.desel();
        chk("frame_abort", 16'h0001, 16'(n_abort));
        chk("frame_end", 16'h0003, 16'(n_end));
        u_host.hold(1'b1);
        pop(8'h06, 1'b1);
        $display("test abort done");
        u_host.sel(1'b0);
        for (int i = 0; i < 17; i++) u_host.xfer(8'(i + 64), -1, r, oe);
        u_host.desel();
        chk("overrun", 16'h0001, 16'(n_ovr));
        for (int i = 0; i < 16; i++) pop(8'(i + 64), i == 0);
        chk("rx_valid", 16'h0000, 16'(rx_valid));
        $display("test fifo done");
        write_busy = 1'b1;
        @(negedge clk);
        chk("standby_busy", 16'h0000, 16'(standby));
        write_busy = 1'b0;
        @(negedge clk);
        chk("standby_idle", 16'h0001, 16'(standby));
        mode_sel = 1'b1;
        wp_n = 1'b0;
        for (int k = 0; k < 4; k++) begin
            part[0] = {2'(k), 6'h3f};
            @(negedge clk);
            chk("zone_pin", 16'(k == PROT_PIN), 16'(zone_pin_guard));
            chk("zone_sw", 16'(k == PROT_SW || k == PROT_SW_LOCKED), 16'(zone_sw_guard));
        end
        mode_sel = 1'b0;
        for (int j = 0; j < 2; j++) begin
            status_word = j ? 16'h008c : 16'h0000;
            @(negedge clk);
            chk("status_guard", 16'(j), 16'(status_guard));
            chk("array_guard", 16'(j), 16'(array_guard));
        end
        wp_n = 1'b1;
        mode_sel = 1'b1;
        part[0] = {2'h2, 6'h3f};
        repeat (3) @(negedge clk);
        chk("zone_pin_wp", 16'h0000, 16'(zone_pin_guard));
        mode_sel = 1'b0;
        @(negedge clk);
        chk("status_wp", 16'h0000, 16'(status_guard));
        $display("test guards done");
        summarize();
    end
endmodule
